// *** sspl_cfg.svh ***
`ifndef SSPL_CFG_SVH
`define SSPL_CFG_SVH

// System clock and dot clock rates
`define SSPL_CLK_MHZ       200
`define SSPL_DOT_MHZ       8
`define SSPL_DOT_DIV       (`SSPL_CLK_MHZ / `SSPL_DOT_MHZ)

// Area widths in dot clocks
`define SSPL_AREA_A_FIXED  12
`define SSPL_AREA_B_DOTS   48
`define SSPL_AREA_C_DOTS   12

// Programmable variant: start position residue modulo 12 selects the area A extension
`define SSPL_HPOS_MOD      12
`define SSPL_HPOS_RES_28   4
`define SSPL_HPOS_RES_25   1
`define SSPL_HPOS_RES_22   10
`define SSPL_HPOS_RES_31   7
`define SSPL_A_EXT_28      7
`define SSPL_A_EXT_25      10
`define SSPL_A_EXT_22      13
`define SSPL_A_EXT_31      16

// Reset values
`define SSPL_LINE_RST      10'h000
`define SSPL_DOT_RST       10'h3FF

`endif

// *** sspl_div.sv ***
`timescale 1ns/10ps
module sspl_div #(
  parameter int DIV = 25
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Dot clock enable
  output logic      en_o
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_r;
  logic          en_r;
  wire           wrap_w = (cnt_r == CW'(DIV - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      en_r  <= 1'b0;
    end else begin
      cnt_r <= wrap_w ? '0 : cnt_r + CW'(1);
      en_r  <= wrap_w;
    end
  end

  assign en_o = en_r;

endmodule

// *** sspl_line_counter.sv ***
`timescale 1ns/10ps
`include "sspl_cfg.svh"
module sspl_line_counter #(
  parameter int DOT_DIV      = `SSPL_DOT_DIV,
  parameter bit PROG_VARIANT = 1'b0,
  parameter int LW           = 10,
  parameter int DW           = 10
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Sync pins, active low
  input  wire logic                 hsync_n_i,
  input  wire logic                 vsync_n_i,
  // Display position settings
  input  wire logic [7:0]           hpos_i,
  input  wire logic [LW-1:0]        vstart_i,
  // Line count results
  output logic                      pseudo_hsync_o,
  output logic                      line_tick_o,
  output logic      [LW-1:0]        line_cnt_o,
  output logic                      vstart_hit_o,
  output sspl_pkg::sspl_area_t      vs_area_o,
  output logic                      pseudo_rec_o
);

  function automatic logic [DW-1:0] area_a_ext(input logic prog, input logic [7:0] hpos);
    logic [7:0] res;
    res = 8'(hpos % `SSPL_HPOS_MOD);
    if (!prog)
      return DW'(`SSPL_AREA_A_FIXED);
    unique case (res)
      8'(`SSPL_HPOS_RES_28): return DW'(`SSPL_A_EXT_28);
      8'(`SSPL_HPOS_RES_25): return DW'(`SSPL_A_EXT_25);
      8'(`SSPL_HPOS_RES_22): return DW'(`SSPL_A_EXT_22);
      8'(`SSPL_HPOS_RES_31): return DW'(`SSPL_A_EXT_31);
      default:               return DW'(`SSPL_AREA_A_FIXED);
    endcase
  endfunction

  function automatic logic [LW-1:0] sat_inc(input logic [LW-1:0] v);
    return (v == '1) ? v : v + LW'(1);
  endfunction

  // Pin synchronisation and dot clock enable
  logic [1:0]          sync_lvl;
  logic [1:0]          sync_rise;
  logic                dot_en;
  sspl_pkg::sspl_evt_t evt;

  sspl_sync #(
    .W (2)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({vsync_n_i, hsync_n_i}),
    .lvl_o   (sync_lvl),
    .rise_o  (sync_rise)
  );

  sspl_div #(
    .DIV (DOT_DIV)
  ) u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .en_o    (dot_en)
  );

  assign evt.hs_low  = ~sync_lvl[0];
  assign evt.hs_rise = sync_rise[0];
  assign evt.vs_rise = sync_rise[1];

  // Dot position within the line, restarted by every horizontal sync rise
  logic [DW-1:0] dot_cnt_r;
  logic [DW-1:0] dot_cnt_nxt;
  wire  [DW-1:0] a_ext_w = area_a_ext(PROG_VARIANT, hpos_i);
  logic [DW-1:0] a_end_r;
  wire  [DW-1:0] a_end_w = a_end_r;
  wire  [DW-1:0] b_end_w = a_end_w + DW'(`SSPL_AREA_B_DOTS);
  wire  [DW-1:0] c_end_w = b_end_w + DW'(`SSPL_AREA_C_DOTS);

  assign dot_cnt_nxt = evt.hs_rise ? '0 :
                       (dot_en && dot_cnt_r != '1) ? dot_cnt_r + DW'(1) : dot_cnt_r;

  // Area decode: A covers the sync low time and the first a_end_w dots after the rise, then B, C, and D for the rest
  sspl_pkg::sspl_area_t area_w;
  sspl_pkg::sspl_area_t area_r;

  assign area_w = (evt.hs_low || dot_cnt_r < a_end_w) ? sspl_pkg::SSPL_AREA_A :
                  (dot_cnt_r < b_end_w) ? sspl_pkg::SSPL_AREA_B :
                  (dot_cnt_r < c_end_w) ? sspl_pkg::SSPL_AREA_C :
                  sspl_pkg::SSPL_AREA_D;

  wire c_start_w = (area_w == sspl_pkg::SSPL_AREA_C) && (area_r != sspl_pkg::SSPL_AREA_C);

  // Decision at the vertical sync rise
  logic rec_r;
  wire  emit_w = (area_w == sspl_pkg::SSPL_AREA_A) ||
                 (area_w == sspl_pkg::SSPL_AREA_B && rec_r) ||
                 (area_w == sspl_pkg::SSPL_AREA_D && rec_r);

  sspl_pkg::sspl_state_t state_r;
  sspl_pkg::sspl_state_t state_nxt;
  logic                  pseudo_nxt;
  logic                  count_w;
  logic                  first_w;

  always_comb begin
    state_nxt  = state_r;
    pseudo_nxt = 1'b0;
    count_w    = 1'b0;
    first_w    = 1'b0;
    if (evt.vs_rise) begin
      state_nxt = emit_w ? sspl_pkg::SSPL_ST_WAIT_PSEUDO : sspl_pkg::SSPL_ST_WAIT_REAL;
    end else begin
      unique case (state_r)
        sspl_pkg::SSPL_ST_IDLE: begin
          state_nxt = state_r;
        end
        sspl_pkg::SSPL_ST_WAIT_REAL: begin
          if (evt.hs_rise) begin
            state_nxt = sspl_pkg::SSPL_ST_COUNT;
            count_w   = 1'b1;
            first_w   = 1'b1;
          end
        end
        sspl_pkg::SSPL_ST_WAIT_PSEUDO: begin
          if (c_start_w) begin
            state_nxt  = sspl_pkg::SSPL_ST_COUNT;
            pseudo_nxt = 1'b1;
            count_w    = 1'b1;
            first_w    = 1'b1;
          end
        end
        sspl_pkg::SSPL_ST_COUNT: begin
          count_w = evt.hs_rise;
        end
      endcase
    end
  end

  wire [LW-1:0] line_nxt_w = first_w ? LW'(1) : sat_inc(line_cnt_o);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dot_cnt_r <= `SSPL_DOT_RST;
      a_end_r   <= DW'(`SSPL_AREA_A_FIXED);
      area_r    <= sspl_pkg::SSPL_AREA_D;
      state_r   <= sspl_pkg::SSPL_ST_IDLE;
      rec_r     <= 1'b0;
    end else begin
      dot_cnt_r <= dot_cnt_nxt;
      // Start position is taken once per line so areas never jump mid-line
      if (evt.hs_rise)
        a_end_r <= a_ext_w;
      area_r    <= area_w;
      state_r   <= state_nxt;
      if (evt.vs_rise)
        rec_r <= emit_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pseudo_hsync_o <= 1'b0;
      line_tick_o    <= 1'b0;
      line_cnt_o     <= `SSPL_LINE_RST;
      vstart_hit_o   <= 1'b0;
      vs_area_o      <= sspl_pkg::SSPL_AREA_D;
    end else begin
      pseudo_hsync_o <= pseudo_nxt;
      line_tick_o    <= count_w;
      vstart_hit_o   <= count_w && (line_nxt_w == vstart_i);
      if (count_w)
        line_cnt_o <= line_nxt_w;
      if (evt.vs_rise)
        vs_area_o <= area_w;
    end
  end

  assign pseudo_rec_o = rec_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_pseudo_in_c;
    pseudo_hsync_o |-> $past(area_w) == sspl_pkg::SSPL_AREA_C && $past(area_r) != sspl_pkg::SSPL_AREA_C;
  endproperty
  a_pseudo_in_c: assert property (p_pseudo_in_c) else $error("pseudo sync outside area C start");

  property p_area_a_emits;
    evt.vs_rise && area_w == sspl_pkg::SSPL_AREA_A |=> state_r == sspl_pkg::SSPL_ST_WAIT_PSEUDO && rec_r;
  endproperty
  a_area_a_emits: assert property (p_area_a_emits) else $error("vsync in A did not arm pseudo sync");

  property p_area_c_none;
    evt.vs_rise && area_w == sspl_pkg::SSPL_AREA_C |=> state_r == sspl_pkg::SSPL_ST_WAIT_REAL && !rec_r;
  endproperty
  a_area_c_none: assert property (p_area_c_none) else $error("vsync in C armed pseudo sync");

  property p_area_b_keeps;
    evt.vs_rise && area_w == sspl_pkg::SSPL_AREA_B |=> rec_r == $past(rec_r);
  endproperty
  a_area_b_keeps: assert property (p_area_b_keeps) else $error("vsync in B changed record");

  property p_area_d_real;
    evt.vs_rise && area_w == sspl_pkg::SSPL_AREA_D && !rec_r |=> state_r == sspl_pkg::SSPL_ST_WAIT_REAL;
  endproperty
  a_area_d_real: assert property (p_area_d_real) else $error("vsync in D without record misrouted");

  property p_first_real;
    state_r == sspl_pkg::SSPL_ST_WAIT_REAL && evt.hs_rise && !evt.vs_rise
      |=> line_tick_o && line_cnt_o == LW'(1);
  endproperty
  a_first_real: assert property (p_first_real) else $error("first real edge not counted as line 1");

  property p_pseudo_first;
    pseudo_hsync_o |-> line_tick_o && line_cnt_o == LW'(1);
  endproperty
  a_pseudo_first: assert property (p_pseudo_first) else $error("pseudo sync not counted as line 1");

  property p_a_width;
    area_r == sspl_pkg::SSPL_AREA_A && area_w == sspl_pkg::SSPL_AREA_B |-> dot_cnt_r == a_end_w;
  endproperty
  a_a_width: assert property (p_a_width) else $error("area A ended at wrong dot");

  property p_b_width;
    area_r == sspl_pkg::SSPL_AREA_B && area_w != sspl_pkg::SSPL_AREA_B && !evt.hs_low
      |-> area_w == sspl_pkg::SSPL_AREA_C && dot_cnt_r == a_end_w + DW'(48);
  endproperty
  a_b_width: assert property (p_b_width) else $error("area B length or order wrong");

  property p_c_width;
    area_r == sspl_pkg::SSPL_AREA_C && area_w == sspl_pkg::SSPL_AREA_D
      |-> dot_cnt_r == a_end_w + DW'(60);
  endproperty
  a_c_width: assert property (p_c_width) else $error("area C length wrong");

  property p_dot_restart;
    evt.hs_rise |=> dot_cnt_r == '0;
  endproperty
  a_dot_restart: assert property (p_dot_restart) else $error("dot count not restarted by hsync");

endmodule

// *** sspl_pkg.sv ***
package sspl_pkg;

  typedef enum logic [1:0] {
    SSPL_AREA_A = 2'h0,
    SSPL_AREA_B = 2'h1,
    SSPL_AREA_C = 2'h3,
    SSPL_AREA_D = 2'h2
  } sspl_area_t;

  typedef enum logic [1:0] {
    SSPL_ST_IDLE        = 2'h0,
    SSPL_ST_WAIT_REAL   = 2'h1,
    SSPL_ST_COUNT       = 2'h3,
    SSPL_ST_WAIT_PSEUDO = 2'h2
  } sspl_state_t;

  typedef struct packed {
    logic hs_low;
    logic hs_rise;
    logic vs_rise;
  } sspl_evt_t;

endpackage

// *** sspl_sync.sv ***
`timescale 1ns/10ps
module sspl_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Asynchronous pins
  input  wire logic [W-1:0] pin_i,
  // Synchronised level and rising edge
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] lvl_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] rise_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '1;
      lvl_r  <= '1;
      prev_r <= '1;
      rise_r <= '0;
    end else begin
      meta_r <= pin_i;
      lvl_r  <= meta_r;
      prev_r <= lvl_r;
      // Only the second and third stages are read, so no metastable value reaches the edge logic
      rise_r <= lvl_r & ~prev_r;
    end
  end

  // Rise is formed from the second stage against the third view of it
  assign lvl_o  = lvl_r;
  assign rise_o = rise_r;

endmodule

// *** sspl_sync_src.sv ***
`timescale 1ns/10ps
module sspl_sync_src #(
  parameter int LINE = 400,
  parameter int LOW  = 40
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Field request and vertical edge offset in clocks after the line edge
  input  wire logic        field_req_i,
  input  wire logic [15:0] vs_ofs_i,
  // Sync pins, active low
  output logic             hsync_n_o,
  output logic             vsync_n_o
);
  logic [15:0] hcnt_r;
  logic [15:0] ofs_r;
  logic [1:0]  lines_r;
  wire         line_end = (hcnt_r == 16'(LINE - 1));

  // Lines idle high in reset; vertical sync stays low until the offset past the second line end per field
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hcnt_r    <= 16'h0000;
      ofs_r     <= 16'h0000;
      lines_r   <= 2'h0;
      hsync_n_o <= 1'b1;
      vsync_n_o <= 1'b1;
    end else begin
      hcnt_r    <= line_end ? 16'h0000 : hcnt_r + 16'h0001;
      hsync_n_o <= !(hcnt_r >= 16'(LINE - LOW - 1) && !line_end);
      if (field_req_i) begin
        vsync_n_o <= 1'b0;
        ofs_r     <= vs_ofs_i;
        lines_r   <= 2'h0;
      end else if (!vsync_n_o) begin
        if (line_end && lines_r != 2'h3) begin
          lines_r <= lines_r + 2'h1;
        end
        if (lines_r >= 2'h2 && hcnt_r == ofs_r) begin
          vsync_n_o <= 1'b1;
        end
      end
    end
  end
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
`define TB_CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t %s", $time, m); end end
module tb;
  localparam int DIV   = 2;
  localparam int LIMIT = 60000;
  logic                 clk       = 1'b0;
  logic                 rst_n     = 1'b0;
  logic                 field_req = 1'b0;
  logic [15:0]          vs_ofs    = 16'h0000;
  logic [7:0]           hpos      = 8'h00;
  logic [9:0]           vstart    = 10'h002;
  wire                  hsync_n;
  wire                  vsync_n;
  wire                  ps_f;
  wire                  tk_f;
  wire                  hit_f;
  wire                  rec_f;
  wire                  ps_p;
  wire [9:0]            cnt_f;
  sspl_pkg::sspl_area_t area_f;
  int                   cyc, last_hs, hs_cnt, ps_cnt, ps_dly, pp_dly, hit_cnt, tk_cnt;
  int                   err_count, cmp_count;
  logic                 hs_q = 1'b1;

  always #2.5 clk = ~clk;

  sspl_sync_src u_src (.clk_i(clk), .rst_n_i(rst_n), .field_req_i(field_req),
    .vs_ofs_i(vs_ofs), .hsync_n_o(hsync_n), .vsync_n_o(vsync_n));
  sspl_line_counter #(.DOT_DIV(DIV)) u_dut (.clk_i(clk), .rst_n_i(rst_n),
    .hsync_n_i(hsync_n), .vsync_n_i(vsync_n), .hpos_i(hpos), .vstart_i(vstart),
    .pseudo_hsync_o(ps_f), .line_tick_o(tk_f), .line_cnt_o(cnt_f), .vstart_hit_o(hit_f),
    .vs_area_o(area_f), .pseudo_rec_o(rec_f));
  sspl_line_counter #(.DOT_DIV(DIV), .PROG_VARIANT(1'b1)) u_dut_prog (.clk_i(clk),
    .rst_n_i(rst_n), .hsync_n_i(hsync_n), .vsync_n_i(vsync_n), .hpos_i(hpos),
    .vstart_i(vstart), .pseudo_hsync_o(ps_p), .line_tick_o(), .line_cnt_o(),
    .vstart_hit_o(), .vs_area_o(), .pseudo_rec_o());

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Line edge times and pulse counts, in clock cycles
  always @(posedge clk) begin
    cyc++;
    if (hsync_n && !hs_q) begin
      last_hs = cyc;
      hs_cnt++;
    end
    hs_q = hsync_n;
    if (ps_f === 1'b1) begin
      ps_cnt++;
      ps_dly = cyc - last_hs;
    end
    if (ps_p === 1'b1) begin
      pp_dly = cyc - last_hs;
    end
    if (hit_f === 1'b1) begin
      hit_cnt++;
    end
    if (tk_f === 1'b1) begin
      tk_cnt++;
    end
    if (cyc == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic run_field(input int ofs, input sspl_pkg::sspl_area_t ar, input logic ps);
    int h, p, t, k;
    @(posedge clk);
    field_req <= 1'b1;
    vs_ofs    <= 16'(ofs);
    @(posedge clk);
    field_req <= 1'b0;
    #1;
    p = ps_cnt;
    t = hit_cnt;
    while (vsync_n !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    h = hs_cnt;
    k = tk_cnt;
    while (hs_cnt < h + 3) begin
      @(posedge clk);
      #1;
    end
    repeat (6) @(posedge clk);
    #1;
    `TB_CHK(area_f, ar, "vertical edge area")
    `TB_CHK(rec_f, ps, "pseudo record")
    `TB_CHK(ps_cnt - p, int'(ps), "pseudo pulse count")
    `TB_CHK(cnt_f, (ps && ar != sspl_pkg::SSPL_AREA_D) ? 10'h004 : 10'h003, "count")
    `TB_CHK(tk_cnt - k, (ps && ar != sspl_pkg::SSPL_AREA_D) ? 4 : 3, "line ticks")
    `TB_CHK(hit_cnt - t, 1, "start line hit")
    if (ps) begin
      `TB_CHK((ps_dly - 4 - 60 * DIV) inside {[-DIV-2:DIV+2]}, 1'b1, "pseudo time")
    end
  endtask

  task automatic check_idle;
    int h;
    #1;
    `TB_CHK({ps_f, hit_f, rec_f, cnt_f}, 13'h0000, "reset outputs")
    `TB_CHK(area_f, sspl_pkg::SSPL_AREA_D, "reset area")
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    h = hs_cnt;
    while (hs_cnt < h + 2) begin
      @(posedge clk);
      #1;
    end
    repeat (6) @(posedge clk);
    #1;
    `TB_CHK(cnt_f, 10'h000, "count before field")
  endtask

  task automatic prog_ext(input logic [7:0] hp, input int ext);
    @(posedge clk);
    hpos <= hp;
    run_field(10, sspl_pkg::SSPL_AREA_A, 1'b1);
    `TB_CHK((pp_dly - 4 - (ext + 48) * DIV) inside {[-DIV-2:DIV+2]}, 1'b1, "ext")
  endtask

  initial begin
    repeat (19) @(posedge clk);
    check_idle();
    run_field(132, sspl_pkg::SSPL_AREA_C, 1'b0);
    run_field(72, sspl_pkg::SSPL_AREA_B, 1'b0);
    run_field(300, sspl_pkg::SSPL_AREA_D, 1'b0);
    run_field(10, sspl_pkg::SSPL_AREA_A, 1'b1);
    run_field(72, sspl_pkg::SSPL_AREA_B, 1'b1);
    run_field(300, sspl_pkg::SSPL_AREA_D, 1'b1);
    run_field(132, sspl_pkg::SSPL_AREA_C, 1'b0);
    prog_ext(8'h1C, 7);
    prog_ext(8'h19, 10);
    prog_ext(8'h16, 13);
    prog_ext(8'h1F, 16);
    prog_ext(8'h00, 12);
    wrap_up();
  end
endmodule
